// [verilog/sbsc_standby_seq.sv]
// standby sensing configuration registers and sampling sequencer
// Operation
// - one enable bit per input, bit n selects input n+1, reset clear.
// - standby inputs use standby threshold, averaging and gain settings.
// - accumulate select clear gives average of samples, set gives their sum.
// - sample count field bits 6..4 selects 1 to 128 samples, default 8.
// - all samples of one input back to back, then result updated.
// - sample period field bits 3..2 gives 320us to 2.56ms, default 1.28ms.
// - cycle period field bits 1..0 gives 35 to 140 ms, default 70ms.
// - sample all enabled inputs at cycle start, then low power.
// - sampling longer than cycle period stretches the cycle.
// - gain field scales delta by 128x down to 1x for codes 0..7.
// - delta msb is 64 raw counts at 128x, 8192 at 1x.
// - sampling config register resets to 39h.
// - gain register resets to 02h, upper five bits unused.
// - input touched when delta exceeds seven-bit threshold, reset 40h.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module sbsc_standby_seq
  import sbsc_pkg::*;
#(
  parameter int SAMPLE_BASE_CYC = SBSC_SAMPLE_BASE_CYC,
  parameter int CYCLE_BASE_CYC  = SBSC_CYCLE_BASE_CYC
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire sbsc_pkg::sbsc_bus_t bus,
  output logic [7:0]             rdata,
  input  wire logic              standby_req,
  input  wire logic [15:0]       raw_count,
  output logic                   sample_active,
  output logic [2:0]             sample_input,
  output logic                   low_power,
  output logic [7:0]             touch
);
  import sbsc_pkg::*;

  // software registers
  logic [7:0]  input_en_r;
  logic [7:0]  cfg_r;
  logic [2:0]  gain_r;
  logic [6:0]  thresh_r;
  // shadow used by the running cycle
  sbsc_cfg_t   act_r;
  // sequencer
  sbsc_state_t state_r;
  sbsc_state_t state_nxt;
  logic [2:0]  chan_r;
  logic [7:0]  samp_idx_r;
  logic [SBSC_STIMER_W-1:0] stimer_r;
  logic [SBSC_CTIMER_W-1:0] ctimer_r;
  logic [SBSC_ACC_W-1:0]    acc_r;
  logic [7:0]  delta_r [8];
  logic [7:0]  touch_r;
  logic [7:0]  rdata_r;

  // decode of the sample count field
  function automatic logic [7:0] samples_of(input logic [2:0] code);
    samples_of = 8'(9'h001 << code) - 8'h01;
  endfunction

  // search the enable mask for the first set bit at or above a start index
  function automatic logic [3:0] next_chan(input logic [7:0] mask,
                                           input logic [3:0] start);
    logic [3:0] res;
    res = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= start)) begin
        res = 4'(i);
      end
    end
    next_chan = res;
  endfunction

  // cycles in one sample
  function automatic logic [SBSC_STIMER_W-1:0] sample_cyc(input logic [1:0] code);
    sample_cyc = SBSC_STIMER_W'(SAMPLE_BASE_CYC) << code;
  endfunction

  // cycles in one sensing cycle
  function automatic logic [SBSC_CTIMER_W-1:0] cycle_cyc(input logic [1:0] code);
    cycle_cyc = SBSC_CTIMER_W'(CYCLE_BASE_CYC) * SBSC_CTIMER_W'({1'b0, code} + 3'h1);
  endfunction

  // average or sum, then gain scaling with saturation
  function automatic logic [7:0] scale(input logic [SBSC_ACC_W-1:0] acc,
                                       input logic                  sum_mode,
                                       input logic [2:0]            cnt,
                                       input logic [2:0]            gain);
    logic [SBSC_ACC_W-1:0] comb;
    logic [SBSC_ACC_W:0]   shifted;
    comb = sum_mode ? acc : (acc >> cnt);
    // 128x means msb weight 64 raw counts, each code step doubles it
    shifted = {comb, 1'b0} >> gain;
    scale = (shifted > (SBSC_ACC_W+1)'(8'hff)) ? 8'hff : shifted[7:0];
  endfunction

  logic        wr_en;
  logic        wr_cfg;
  logic        wr_gain;
  logic        wr_thr;
  logic        samp_done;
  logic        chan_done;
  logic        cycle_over;
  logic [3:0]  first_chan;
  logic [3:0]  later_chan;
  logic [7:0]  new_delta;

  assign wr_en   = bus.wr && (bus.addr == SBSC_ADDR_INPUT_EN);
  assign wr_cfg  = bus.wr && (bus.addr == SBSC_ADDR_CFG);
  assign wr_gain = bus.wr && (bus.addr == SBSC_ADDR_GAIN);
  assign wr_thr  = bus.wr && (bus.addr == SBSC_ADDR_THRESH);

  assign samp_done  = (state_r == SBSC_ST_SAMPLE) && (stimer_r == '0);
  assign chan_done  = samp_done && (samp_idx_r == samples_of(act_r.standby_sample_count));
  assign cycle_over = (ctimer_r == '0);
  assign first_chan = next_chan(input_en_r, 4'h0);
  assign later_chan = next_chan(act_r.input_en, {1'b0, chan_r} + 4'h1);
  assign new_delta  = scale(acc_r + SBSC_ACC_W'(raw_count), act_r.accumulate_select,
                            act_r.standby_sample_count, act_r.standby_gain_select);

  // software registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      input_en_r <= SBSC_RST_INPUT_EN;
      cfg_r      <= SBSC_RST_CFG;
      gain_r     <= SBSC_RST_GAIN[2:0];
      thresh_r   <= SBSC_RST_THRESH;
    end else begin
      if (wr_en) begin
        input_en_r <= bus.wdata;
      end
      if (wr_cfg) begin
        cfg_r <= bus.wdata;
      end
      if (wr_gain) begin
        gain_r <= bus.wdata[SBSC_GAIN_LSB +: 3];
      end
      if (wr_thr) begin
        thresh_r <= bus.wdata[6:0];
      end
    end
  end

  // read data, valid the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (bus.rd) begin
      if (bus.addr == SBSC_ADDR_INPUT_EN) begin
        rdata_r <= input_en_r;
      end else if (bus.addr == SBSC_ADDR_CFG) begin
        rdata_r <= cfg_r;
      end else if (bus.addr == SBSC_ADDR_GAIN) begin
        rdata_r <= {5'h00, gain_r};
      end else if (bus.addr == SBSC_ADDR_THRESH) begin
        rdata_r <= {1'b0, thresh_r};
      end else if (bus.addr == SBSC_ADDR_TOUCH) begin
        rdata_r <= touch_r;
      end else if ((bus.addr >= SBSC_ADDR_DELTA0) && (bus.addr <= SBSC_ADDR_DELTA7)) begin
        rdata_r <= delta_r[bus.addr[2:0]];
      end else begin
        rdata_r <= 8'h00;
      end
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // state transitions
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SBSC_ST_OFF: begin
        if (standby_req) begin
          state_nxt = (first_chan[3]) ? SBSC_ST_REST : SBSC_ST_SAMPLE;
        end
      end
      SBSC_ST_SAMPLE: begin
        if (chan_done && later_chan[3]) begin
          state_nxt = SBSC_ST_REST;
        end
      end
      SBSC_ST_REST: begin
        if (!standby_req) begin
          state_nxt = SBSC_ST_OFF;
        end else if (cycle_over) begin
          state_nxt = (first_chan[3]) ? SBSC_ST_REST : SBSC_ST_SAMPLE;
        end
      end
      default: begin
        state_nxt = SBSC_ST_OFF;
      end
    endcase
  end

  logic cycle_start;
  assign cycle_start = standby_req &&
                       ((state_r == SBSC_ST_OFF) || ((state_r == SBSC_ST_REST) && cycle_over));

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_r <= SBSC_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // shadow settings are latched only when a cycle starts
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      act_r <= '0;
    end else if (cycle_start) begin
      act_r.input_en              <= input_en_r;
      act_r.accumulate_select     <= cfg_r[SBSC_ACC_SEL_BIT];
      act_r.standby_sample_count  <= cfg_r[SBSC_CNT_LSB +: 3];
      act_r.standby_sample_period <= cfg_r[SBSC_SPER_LSB +: 2];
      act_r.standby_cycle_period  <= cfg_r[SBSC_CPER_LSB +: 2];
      act_r.standby_gain_select   <= gain_r;
      act_r.thresh                <= thresh_r;
    end
  end

  // cycle timer: loaded at cycle start, stops at zero, so sampling may overrun it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctimer_r <= '0;
    end else if (cycle_start) begin
      ctimer_r <= cycle_cyc(cfg_r[SBSC_CPER_LSB +: 2]) - SBSC_CTIMER_W'(1);
    end else if (ctimer_r != '0) begin
      ctimer_r <= ctimer_r - SBSC_CTIMER_W'(1);
    end
  end

  // sample timer and channel / sample indices
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stimer_r   <= '0;
      samp_idx_r <= 8'h00;
      chan_r     <= 3'h0;
    end else if (cycle_start) begin
      stimer_r   <= sample_cyc(cfg_r[SBSC_SPER_LSB +: 2]) - SBSC_STIMER_W'(1);
      samp_idx_r <= 8'h00;
      chan_r     <= first_chan[2:0];
    end else if (state_r == SBSC_ST_SAMPLE) begin
      if (!samp_done) begin
        stimer_r <= stimer_r - SBSC_STIMER_W'(1);
      end else begin
        stimer_r <= sample_cyc(act_r.standby_sample_period) - SBSC_STIMER_W'(1);
        if (chan_done) begin
          samp_idx_r <= 8'h00;
          chan_r     <= later_chan[2:0];
        end else begin
          samp_idx_r <= samp_idx_r + 8'h01;
        end
      end
    end
  end

  // accumulation over the samples of one input
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      acc_r <= '0;
    end else if (cycle_start || chan_done) begin
      acc_r <= '0;
    end else if (samp_done) begin
      acc_r <= acc_r + SBSC_ACC_W'(raw_count);
    end
  end

  // per-input results, updated once all samples are in
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < 8; i++) begin
        delta_r[i] <= 8'h00;
      end
      touch_r <= 8'h00;
    end else if (chan_done) begin
      delta_r[chan_r] <= new_delta;
      touch_r[chan_r] <= (new_delta > {1'b0, act_r.thresh});
    end
  end

  assign rdata         = rdata_r;
  assign touch         = touch_r;
  assign sample_active = (state_r == SBSC_ST_SAMPLE);
  assign sample_input  = chan_r;
  assign low_power     = (state_r == SBSC_ST_REST);

endmodule

`default_nettype wire

// [include/sbsc_pkg.sv]
// package for the standby sensing configuration and sequencer block
package sbsc_pkg;

  // register offsets
  localparam logic [7:0] SBSC_ADDR_INPUT_EN = 8'h40;
  localparam logic [7:0] SBSC_ADDR_CFG      = 8'h41;
  localparam logic [7:0] SBSC_ADDR_GAIN     = 8'h42;
  localparam logic [7:0] SBSC_ADDR_THRESH   = 8'h43;
  localparam logic [7:0] SBSC_ADDR_TOUCH    = 8'h44;
  localparam logic [7:0] SBSC_ADDR_DELTA0   = 8'h48;
  localparam logic [7:0] SBSC_ADDR_DELTA7   = 8'h4f;

  // reset values
  localparam logic [7:0] SBSC_RST_INPUT_EN = 8'h00;
  localparam logic [7:0] SBSC_RST_CFG      = 8'h39;
  localparam logic [7:0] SBSC_RST_GAIN     = 8'h02;
  localparam logic [6:0] SBSC_RST_THRESH   = 7'h40;

  // field positions in the sampling config and gain registers
  localparam int SBSC_ACC_SEL_BIT  = 7;
  localparam int SBSC_CNT_LSB      = 4;
  localparam int SBSC_SPER_LSB     = 2;
  localparam int SBSC_CPER_LSB     = 0;
  localparam int SBSC_GAIN_LSB     = 0;

  // timing
  localparam int SBSC_CLK_MHZ          = 100;
  localparam int SBSC_SAMPLE_TIME_US   = 320;
  localparam int SBSC_CYCLE_TIME_MS    = 35;
  localparam int SBSC_SAMPLE_BASE_CYC  = SBSC_SAMPLE_TIME_US * SBSC_CLK_MHZ;
  localparam int SBSC_CYCLE_BASE_CYC   = SBSC_CYCLE_TIME_MS * 1000 * SBSC_CLK_MHZ;
  localparam int SBSC_STIMER_W         = 20;
  localparam int SBSC_CTIMER_W         = 26;
  localparam int SBSC_ACC_W            = 23;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sbsc_bus_t;

  typedef struct packed {
    logic [7:0] input_en;
    logic       accumulate_select;
    logic [2:0] standby_sample_count;
    logic [1:0] standby_sample_period;
    logic [1:0] standby_cycle_period;
    logic [2:0] standby_gain_select;
    logic [6:0] thresh;
  } sbsc_cfg_t;

  typedef enum logic [1:0] {
    SBSC_ST_OFF    = 2'b00,
    SBSC_ST_SAMPLE = 2'b01,
    SBSC_ST_REST   = 2'b10
  } sbsc_state_t;

endpackage

// [verification/sbsc_chk_properties.sv]
// assertions on the standby sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sbsc_chk
  import sbsc_pkg::*;
#(
  parameter int SAMPLE_BASE_CYC = 4,
  parameter int CYCLE_BASE_CYC  = 200
) (
  input wire logic                core_clk,
  input wire logic                nrst,
  input wire sbsc_pkg::sbsc_bus_t bus,
  input wire logic [7:0]          rdata,
  input wire logic                standby_req,
  input wire logic [15:0]         raw_count,
  input wire logic                sample_active,
  input wire logic [2:0]          sample_input,
  input wire logic                low_power,
  input wire logic [7:0]          touch
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd(a);
    bus.rd && bus.addr == a;
  endsequence
  sequence s_step;
    sample_active && $past(sample_active) && sample_input != $past(sample_input);
  endsequence
  property p_idle; !$past(bus.rd) |-> rdata == 8'h00; endproperty
  property p_gain; s_rd(SBSC_ADDR_GAIN) |=> rdata[7:3] == 5'h00; endproperty
  property p_thr; s_rd(SBSC_ADDR_THRESH) |=> !rdata[7]; endproperty
  property p_rst;
    disable iff (1'b0) !nrst |=> rdata == 8'h00 && touch == 8'h00 && !sample_active;
  endproperty
  property p_excl; !(sample_active && low_power); endproperty
  property p_order; s_step |-> sample_input > $past(sample_input); endproperty
  property p_start; $rose(sample_active) |-> $past(standby_req); endproperty
  property p_samp; $rose(sample_active) |-> sample_active [*4]; endproperty
  property p_touch;
    $changed(touch) |-> $past(sample_active) || $past(sample_active, 2);
  endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  a_gain: assert property (p_gain) else $error("gain unused bits set");
  a_thr: assert property (p_thr) else $error("threshold bit7 set");
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  a_excl: assert property (p_excl) else $error("sampling in low power");
  a_order: assert property (p_order) else $error("input order wrong");
  a_start: assert property (p_start) else $error("cycle without request");
  a_samp: assert property (p_samp) else $error("sample too short");
  a_touch: assert property (p_touch) else $error("touch changed idle");
endmodule
bind sbsc_standby_seq sbsc_chk #(
  .SAMPLE_BASE_CYC(SAMPLE_BASE_CYC),
  .CYCLE_BASE_CYC(CYCLE_BASE_CYC)
) u_chk (.core_clk, .nrst, .bus, .rdata, .standby_req, .raw_count,
  .sample_active, .sample_input, .low_power, .touch);
`default_nettype wire

// [verification/sbsc_front.sv]
// sensing front end model: raw count of the input being sampled
`timescale 1ns/1ps
`default_nettype none
module sbsc_front (
  input  wire logic        core_clk,
  input  wire logic        sample_active,
  input  wire logic [2:0]  sample_input,
  input  wire logic [7:0][15:0] levels,
  output var logic  [15:0] raw_count = 16'h0000
);
  // outside sampling the value is not held, it toggles each cycle
  always_ff @(posedge core_clk) begin
    if (sample_active) raw_count <= levels[sample_input];
    else raw_count <= ~raw_count;
  end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the standby sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sbsc_pkg::*;
  localparam int SB = 4;
  localparam int CB = 200;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  sbsc_bus_t bus = '0;
  logic standby_req = 1'b0;
  logic [7:0][15:0] levels = '0;
  logic [15:0] raw_count;
  logic [7:0] rdata, touch;
  logic [2:0] sample_input;
  logic sample_active, low_power;
  int n_errors = 0, n_tests = 0, cyc = 0, act_n = 0, tot_n = 0;
  sbsc_standby_seq #(.SAMPLE_BASE_CYC(SB), .CYCLE_BASE_CYC(CB)) dut (.core_clk, .nrst,
    .bus, .rdata, .standby_req, .raw_count, .sample_active, .sample_input, .low_power, .touch);
  sbsc_front u_front (.core_clk, .sample_active, .sample_input, .levels, .raw_count);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
    v = rdata;
  endtask
  task automatic run(logic [7:0] en, logic [7:0] cfg, logic [7:0] g);
    int t;
    logic rest_seen;
    wr(SBSC_ADDR_INPUT_EN, en);
    wr(SBSC_ADDR_CFG, cfg);
    wr(SBSC_ADDR_GAIN, g);
    t = 0;
    rest_seen = 1'b0;
    act_n = 0;
    tot_n = 0;
    standby_req <= 1'b1;
    // count one whole cycle, up to the start of the next one
    while (t < 5000) begin
      @(negedge core_clk);
      t++;
      if (rest_seen && !low_power) break;
      rest_seen = rest_seen | low_power;
      act_n += int'(sample_active);
      tot_n += int'(sample_active | low_power);
    end
    // leaving standby ends at the next rest, after sampling is done
    @(posedge core_clk);
    standby_req <= 1'b0;
    while ((low_power || sample_active) && t < 5000) begin
      @(posedge core_clk);
      t++;
    end
    if (t >= 5000) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic t_regs();
    logic [7:0] v;
    logic [7:0] rv [4] = '{8'h00, 8'h39, 8'h02, 8'h40};
    logic [7:0] mv [4] = '{8'hff, 8'hff, 8'h07, 8'h7f};
    for (int i = 0; i < 4; i++) begin
      rd(8'h40 + 8'(i), v);
      check("reset", 16'(v), 16'(rv[i]));
      wr(8'h40 + 8'(i), 8'hff);
      rd(8'h40 + 8'(i), v);
      check("rw", 16'(v), 16'(mv[i]));
    end
    wr(SBSC_ADDR_THRESH, 8'(SBSC_RST_THRESH));
  endtask
  task automatic t_gain();
    logic [7:0] v;
    for (int g = 0; g < 8; g++) begin
      levels[0] <= 16'h0040 << g;
      run(8'h01, {4'h0, 2'(g), 2'(g)}, 8'(g));
      rd(SBSC_ADDR_DELTA0, v);
      check("delta", 16'(v), 16'h0080);
      check("touch", 16'(touch), 16'h0001);
      check("samp", 16'(act_n), 16'(SB << (g % 4)));
      check("cycle", 16'(tot_n), 16'(CB * (g % 4 + 1)));
    end
  endtask
  task automatic t_count();
    logic [7:0] v;
    int n;
    levels[1] <= 16'h0010;
    levels[7] <= 16'h0001;
    for (int c = 0; c < 8; c++) begin
      n = 1 << c;
      run(8'h82, {1'b1, 3'(c), 4'h0}, 8'h04);
      rd(SBSC_ADDR_DELTA0 + 8'h01, v);
      check("sum2", 16'(v), (n > 127) ? 16'h00ff : 16'(2 * n));
      rd(SBSC_ADDR_DELTA7, v);
      check("sum8", 16'(v), 16'(n / 8));
      rd(SBSC_ADDR_DELTA0, v);
      check("held", 16'(v), 16'h0080);
      check("touch", 16'(touch), (c > 5) ? 16'h0003 : 16'h0001);
      check("samp", 16'(act_n), 16'(8 * n));
      check("cycle", 16'(tot_n), 16'((8 * n > CB) ? 8 * n + 1 : CB));
    end
    run(8'h02, 8'h30, 8'h04);
    rd(SBSC_ADDR_DELTA0 + 8'h01, v);
    check("avg", 16'(v), 16'h0002);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_gain();
    t_count();
    stop_test();
  end
endmodule
`default_nettype wire
